// file: rtl/ccsp_pkg.sv
package ccsp_pkg;

  // ---------------------------------------------------------------
  // special register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CCSP_ADDR_SFR_LO     = 8'h80;
  localparam logic [7:0] CCSP_ADDR_STACK      = 8'h81;
  localparam logic [7:0] CCSP_ADDR_FPTR_LOW   = 8'h82;
  localparam logic [7:0] CCSP_ADDR_FPTR_HIGH  = 8'h83;
  localparam logic [7:0] CCSP_ADDR_STATUS     = 8'hD0;
  localparam logic [7:0] CCSP_ADDR_OPERAND    = 8'hE0;
  localparam logic [2:0] CCSP_BITADDR_LOW_BITS = 3'h0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CCSP_RST_STACK      = 8'h07;
  localparam logic [7:0] CCSP_RST_STATUS     = 8'h00;
  localparam logic [7:0] CCSP_RST_OPERAND    = 8'h00;
  localparam logic [7:0] CCSP_RST_FPTR_LOW   = 8'h00;
  localparam logic [7:0] CCSP_RST_FPTR_HIGH  = 8'h00;

  // ---------------------------------------------------------------
  // status word field positions
  // ---------------------------------------------------------------
  localparam int CCSP_BIT_CARRY  = 7;
  localparam int CCSP_BIT_HALF   = 6;
  localparam int CCSP_BIT_USER0  = 5;
  localparam int CCSP_BIT_BANKHI = 4;
  localparam int CCSP_BIT_BANKLO = 3;
  localparam int CCSP_BIT_WRAP   = 2;
  localparam int CCSP_BIT_USER1  = 1;
  localparam int CCSP_BIT_PARITY = 0;

  localparam logic [8:0] CCSP_MUL_LIMIT = 9'h0FF;

  // ---------------------------------------------------------------
  // arithmetic operation codes from the execution unit
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CCSP_OP_NONE = 4'h0,
    CCSP_OP_ADD  = 4'h1,
    CCSP_OP_ADDC = 4'h2,
    CCSP_OP_SUBB = 4'h3,
    CCSP_OP_MUL  = 4'h4,
    CCSP_OP_DIV  = 4'h5
  } ccsp_op_t;

  typedef struct packed {
    logic       carry_flag;
    logic       half_carry_flag;
    logic       user_flag_zero;
    logic       bank_select_high;
    logic       bank_select_low;
    logic       arith_wrap_flag;
    logic       user_flag_one;
    logic       parity;
  } ccsp_status_t;

  // software special-register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } ccsp_sfr_req_t;

  // execution-unit update requests
  typedef struct packed {
    ccsp_op_t   op;
    logic [7:0] operand;
    logic [7:0] divisor;
    logic       acc_load;
    logic [7:0] acc_value;
    logic       push;
    logic       pop;
    logic       fptr_inc;
  } ccsp_exec_t;

  typedef struct packed {
    logic [7:0]   stack_top_ptr;
    ccsp_status_t program_status_word;
    logic [7:0]   primary_operand_reg;
    logic [7:0]   flash_pointer_low;
    logic [7:0]   flash_pointer_high;
  } ccsp_state_t;

endpackage : ccsp_pkg

// file: rtl/ccsp_alu_flags.sv
`timescale 1ns/10ps
module ccsp_alu_flags
  import ccsp_pkg::*;
(
  // operation in
  input  wire ccsp_op_t   op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] divisor,
  input  wire logic       carry_in,
  // results out
  output logic [7:0] result,
  output logic       arith_op,
  output logic       carry_out,
  output logic       half_out,
  output logic       wrap_touch,
  output logic       wrap_out
);

  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;

  always_comb
  begin
    sum9       = 9'h000;
    nib5       = 5'h00;
    prod       = 16'h0000;
    result     = acc;
    arith_op   = 1'b0;
    carry_out  = 1'b0;
    half_out   = 1'b0;
    wrap_touch = 1'b0;
    wrap_out   = 1'b0;
    case (op)
      CCSP_OP_ADD, CCSP_OP_ADDC:
      begin
        sum9 = {1'b0, acc} + {1'b0, operand} + {8'h00, (op == CCSP_OP_ADDC) & carry_in};
        nib5 = {1'b0, acc[3:0]} + {1'b0, operand[3:0]}
             + {4'h0, (op == CCSP_OP_ADDC) & carry_in};
        result     = sum9[7:0];
        arith_op   = 1'b1;
        carry_out  = sum9[8];
        half_out   = nib5[4];
        wrap_touch = 1'b1;
        wrap_out   = (acc[7] == operand[7]) && (sum9[7] != acc[7]);
      end
      CCSP_OP_SUBB:
      begin
        sum9 = {1'b0, acc} - {1'b0, operand} - {8'h00, carry_in};
        nib5 = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, carry_in};
        result     = sum9[7:0];
        arith_op   = 1'b1;
        carry_out  = sum9[8];
        half_out   = nib5[4];
        wrap_touch = 1'b1;
        wrap_out   = (acc[7] != operand[7]) && (sum9[7] != acc[7]);
      end
      CCSP_OP_MUL:
      begin
        prod       = {8'h00, acc} * {8'h00, divisor};
        result     = prod[7:0];
        arith_op   = 1'b1;
        wrap_touch = 1'b1;
        wrap_out   = (prod > {7'h00, CCSP_MUL_LIMIT});
      end
      CCSP_OP_DIV:
      begin
        result     = (divisor == 8'h00) ? acc : acc / divisor;
        arith_op   = 1'b1;
        wrap_touch = 1'b1;
        wrap_out   = (divisor == 8'h00);
      end
      default:
      begin
        result = acc;
      end
    endcase
  end

endmodule : ccsp_alu_flags

// file: rtl/ccsp_core_regs.sv
`timescale 1ns/10ps
module ccsp_core_regs
  import ccsp_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // special register access
  input  wire ccsp_sfr_req_t sfr_req,
  output logic [7:0]         sfr_rdata,
  output logic               sfr_hit,
  // execution unit
  input  wire ccsp_exec_t    exec,
  // state out
  output logic [15:0]        flash_pointer_word,
  output logic [7:0]         stack_top_ptr,
  output logic [7:0]         push_addr,
  output logic [7:0]         primary_operand_reg,
  output ccsp_status_t       program_status_word,
  output logic [4:0]         bank_base_addr
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  ccsp_state_t st;
  ccsp_state_t next_st;

  logic [7:0] alu_result;
  logic       alu_arith;
  logic       alu_carry;
  logic       alu_half;
  logic       alu_wrap_touch;
  logic       alu_wrap;
  logic       parity_now;
  logic       bit_ok;
  logic [7:0] cur_byte;
  logic [7:0] wr_byte;
  logic [7:0] status_byte;

  ccsp_alu_flags u_alu (
    .op         (exec.op),
    .acc        (st.primary_operand_reg),
    .operand    (exec.operand),
    .divisor    (exec.divisor),
    .carry_in   (st.program_status_word.carry_flag),
    .result     (alu_result),
    .arith_op   (alu_arith),
    .carry_out  (alu_carry),
    .half_out   (alu_half),
    .wrap_touch (alu_wrap_touch),
    .wrap_out   (alu_wrap)
  );

  // -----------------------------------------------------------------
  // access decode
  // -----------------------------------------------------------------
  assign parity_now = ^st.primary_operand_reg;
  assign bit_ok     = (sfr_req.addr[2:0] == CCSP_BITADDR_LOW_BITS);

  always_comb
  begin
    status_byte = st.program_status_word;
    status_byte[CCSP_BIT_PARITY] = parity_now;
    sfr_hit  = 1'b1;
    cur_byte = 8'h00;
    if (sfr_req.addr < CCSP_ADDR_SFR_LO)
    begin
      sfr_hit = 1'b0;
    end
    else
    begin
      case (sfr_req.addr)
        CCSP_ADDR_STACK:     cur_byte = st.stack_top_ptr;
        CCSP_ADDR_FPTR_LOW:  cur_byte = st.flash_pointer_low;
        CCSP_ADDR_FPTR_HIGH: cur_byte = st.flash_pointer_high;
        CCSP_ADDR_STATUS:    cur_byte = status_byte;
        CCSP_ADDR_OPERAND:   cur_byte = st.primary_operand_reg;
        default:             sfr_hit  = 1'b0;
      endcase
    end
    if (sfr_req.bit_op && !bit_ok)
    begin
      sfr_hit = 1'b0;
    end
  end

  // bit writes merge one bit into the current byte
  always_comb
  begin
    wr_byte = sfr_req.wdata;
    if (sfr_req.bit_op)
    begin
      wr_byte = cur_byte;
      wr_byte[sfr_req.bit_sel] = sfr_req.wdata[0];
    end
  end

  // read data: byte, or selected bit in bit 0
  always_comb
  begin
    sfr_rdata = 8'h00;
    if (sfr_req.rd && sfr_hit)
    begin
      sfr_rdata = sfr_req.bit_op ? {7'h00, cur_byte[sfr_req.bit_sel]} : cur_byte;
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    // flags and accumulator from the execution unit
    if (alu_arith)
    begin
      next_st.program_status_word.carry_flag      = alu_carry;
      next_st.program_status_word.half_carry_flag = alu_half;
    end
    if (alu_wrap_touch)
    begin
      next_st.program_status_word.arith_wrap_flag = alu_wrap;
    end
    if (exec.op != CCSP_OP_NONE)
    begin
      next_st.primary_operand_reg = alu_result;
    end
    else if (exec.acc_load)
    begin
      next_st.primary_operand_reg = exec.acc_value;
    end

    // stack and flash pointer movement
    if (exec.push)
    begin
      next_st.stack_top_ptr = st.stack_top_ptr + 8'h01;
    end
    else if (exec.pop)
    begin
      next_st.stack_top_ptr = st.stack_top_ptr - 8'h01;
    end
    if (exec.fptr_inc)
    begin
      {next_st.flash_pointer_high, next_st.flash_pointer_low} =
        {st.flash_pointer_high, st.flash_pointer_low} + 16'h0001;
    end

    // software writes win over execution updates in the same cycle
    if (sfr_req.wr && sfr_hit)
    begin
      case (sfr_req.addr)
        CCSP_ADDR_STACK:     next_st.stack_top_ptr      = wr_byte;
        CCSP_ADDR_FPTR_LOW:  next_st.flash_pointer_low  = wr_byte;
        CCSP_ADDR_FPTR_HIGH: next_st.flash_pointer_high = wr_byte;
        CCSP_ADDR_STATUS:
        begin
          next_st.program_status_word = wr_byte;
          next_st.program_status_word.parity = 1'b0;
        end
        CCSP_ADDR_OPERAND:   next_st.primary_operand_reg = wr_byte;
        default:             next_st = next_st;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.stack_top_ptr       <= CCSP_RST_STACK;
      st.program_status_word <= CCSP_RST_STATUS;
      st.primary_operand_reg <= CCSP_RST_OPERAND;
      st.flash_pointer_low   <= CCSP_RST_FPTR_LOW;
      st.flash_pointer_high  <= CCSP_RST_FPTR_HIGH;
    end
    else
    begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign flash_pointer_word  = {st.flash_pointer_high, st.flash_pointer_low};
  assign stack_top_ptr       = st.stack_top_ptr;
  assign push_addr           = st.stack_top_ptr + 8'h01;
  assign primary_operand_reg = st.primary_operand_reg;
  assign program_status_word = status_byte;
  assign bank_base_addr      = {st.program_status_word.bank_select_high,
                                st.program_status_word.bank_select_low, 3'h0};

endmodule : ccsp_core_regs

// file: sim/ccsp_core_regs_assertions.sv
`timescale 1ns/10ps
module ccsp_core_regs_chk
  import ccsp_pkg::*;
(
  // clock and reset
  input wire logic          clock,
  input wire logic          arst_n,
  // register access
  input wire ccsp_sfr_req_t sfr_req,
  input wire logic [7:0]    sfr_rdata,
  input wire logic          sfr_hit,
  // execution and state
  input wire ccsp_exec_t    exec,
  input wire logic [15:0]   flash_pointer_word,
  input wire logic [7:0]    stack_top_ptr,
  input wire logic [7:0]    primary_operand_reg,
  input wire ccsp_status_t  program_status_word,
  input wire logic [4:0]    bank_base_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic        st_wr;
  logic        sp_wr;
  logic [8:0]  add_sum;
  logic        add_cy;
  logic [15:0] prod;
  logic        mul_big;
  assign st_wr   = sfr_req.wr && sfr_hit && sfr_req.addr == CCSP_ADDR_STATUS;
  assign sp_wr   = sfr_req.wr && sfr_hit && sfr_req.addr == CCSP_ADDR_STACK;
  assign add_sum = {1'b0, primary_operand_reg} + {1'b0, exec.operand};
  assign add_cy  = add_sum[8];
  assign prod    = primary_operand_reg * exec.divisor;
  assign mul_big = prod > 16'h00FF;

  a_parity_acc: assert property (program_status_word.parity == ^primary_operand_reg)
    else $error("parity bit off");
  a_push_step: assert property (exec.push && !exec.pop && !sp_wr |=>
    stack_top_ptr == $past(stack_top_ptr) + 8'h01) else $error("push step wrong");
  a_fptr_low: assert property (sfr_req.rd && sfr_req.addr == CCSP_ADDR_FPTR_LOW
    && !sfr_req.bit_op |-> sfr_rdata == flash_pointer_word[7:0]) else $error("pointer low");
  a_bank_base: assert property (bank_base_addr == {program_status_word.bank_select_high,
    program_status_word.bank_select_low, 3'h0}) else $error("bank base wrong");
  a_user_keep: assert property (!st_wr |=> $stable(program_status_word.user_flag_zero)
    && $stable(program_status_word.user_flag_one)) else $error("user flag moved");
  a_carry_add: assert property (exec.op == CCSP_OP_ADD && !st_wr |=>
    program_status_word.carry_flag == $past(add_cy)) else $error("add carry wrong");
  a_mul_wrap: assert property (exec.op == CCSP_OP_MUL && !st_wr |=>
    program_status_word.arith_wrap_flag == $past(mul_big)) else $error("mul overflow");
  a_div_zero: assert property (exec.op == CCSP_OP_DIV && exec.divisor == 8'h00 && !st_wr
    |=> program_status_word.arith_wrap_flag) else $error("div zero flag");
  a_muldiv_clear: assert property ((exec.op == CCSP_OP_MUL || exec.op == CCSP_OP_DIV) && !st_wr
    |=> !program_status_word.carry_flag && !program_status_word.half_carry_flag)
    else $error("carry not cleared");
  a_refused_read: assert property (sfr_req.rd && !sfr_hit |-> sfr_rdata == 8'h00)
    else $error("refused read not zero");

  cover property (exec.push);
  cover property (exec.op == CCSP_OP_MUL);
  cover property (st_wr);
endmodule : ccsp_core_regs_chk

bind ccsp_core_regs ccsp_core_regs_chk u_chk (.clock(clock), .arst_n(arst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .exec(exec),
  .flash_pointer_word(flash_pointer_word), .stack_top_ptr(stack_top_ptr),
  .primary_operand_reg(primary_operand_reg), .program_status_word(program_status_word),
  .bank_base_addr(bank_base_addr));

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench
  import ccsp_pkg::*;
;
  logic          clock;
  logic          arst_n;
  ccsp_sfr_req_t sfr_req;
  ccsp_exec_t    exec;
  logic [7:0]    sfr_rdata;
  logic          sfr_hit;
  logic [15:0]   flash_pointer_word;
  logic [7:0]    stack_top_ptr;
  logic [7:0]    push_addr;
  logic [7:0]    primary_operand_reg;
  ccsp_status_t  program_status_word;
  logic [4:0]    bank_base_addr;
  int            fail_count;
  int            check_count;

  ccsp_core_regs DUT (.clock(clock), .arst_n(arst_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .exec(exec),
    .flash_pointer_word(flash_pointer_word), .stack_top_ptr(stack_top_ptr),
    .push_addr(push_addr), .primary_operand_reg(primary_operand_reg),
    .program_status_word(program_status_word), .bank_base_addr(bank_base_addr));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task req(input logic w, input logic b, input logic [7:0] a, input logic [2:0] s,
           input logic [7:0] d);
    @(negedge clock);
    sfr_req = '{wr: w, rd: !w, bit_op: b, addr: a, bit_sel: s, wdata: d};
  endtask : req

  // one-cycle write strobe, then idle
  task wr(input logic b, input logic [7:0] a, input logic [2:0] s, input logic [7:0] d);
    req(1'b1, b, a, s, d);
    @(negedge clock);
    sfr_req = '0;
  endtask : wr

  task rd(input logic b, input logic [7:0] a, input logic [2:0] s, input logic [7:0] e,
          input logic h);
    req(1'b0, b, a, s, 8'h00);
    #10;
    chk(sfr_rdata, e);
    chk(sfr_hit, h);
    @(negedge clock);
    sfr_req = '0;
  endtask : rd

  task ex(input ccsp_exec_t e);
    @(negedge clock);
    exec = e;
    @(negedge clock);
    exec = '{op: CCSP_OP_NONE, default: '0};
  endtask : ex

  task ar(input ccsp_op_t o, input logic [7:0] p, input logic [7:0] v, input logic [7:0] ea,
          input logic [7:0] es);
    ex('{op: o, operand: p, divisor: v, default: '0});
    chk(primary_operand_reg, ea);
    chk(program_status_word, es);
  endtask : ar

  initial
  begin
    #(100 * 4000);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    fail_count = 0;
    check_count = 0;
    sfr_req = '0;
    exec = '{op: CCSP_OP_NONE, default: '0};
    arst_n = 1'b0;
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    rd(1'b0, CCSP_ADDR_STACK, 3'h0, 8'h07, 1'b1);
    rd(1'b0, CCSP_ADDR_STATUS, 3'h0, 8'h00, 1'b1);
    rd(1'b0, CCSP_ADDR_OPERAND, 3'h0, 8'h00, 1'b1);
    rd(1'b0, CCSP_ADDR_FPTR_HIGH, 3'h0, 8'h00, 1'b1);
    wr(1'b0, CCSP_ADDR_FPTR_LOW, 3'h0, 8'h34);
    wr(1'b0, CCSP_ADDR_FPTR_HIGH, 3'h0, 8'h12);
    chk(flash_pointer_word, 16'h1234);
    rd(1'b0, CCSP_ADDR_FPTR_LOW, 3'h0, 8'h34, 1'b1);
    rd(1'b0, CCSP_ADDR_FPTR_HIGH, 3'h0, 8'h12, 1'b1);
    rd(1'b0, 8'h97, 3'h0, 8'h00, 1'b0);
    wr(1'b0, 8'hAE, 3'h0, 8'h55);
    rd(1'b0, 8'hAE, 3'h0, 8'h00, 1'b0);
    rd(1'b1, CCSP_ADDR_STACK, 3'h0, 8'h00, 1'b0);
    wr(1'b0, CCSP_ADDR_OPERAND, 3'h0, 8'h07);
    chk(program_status_word, 8'h01);
    wr(1'b0, CCSP_ADDR_STATUS, 3'h0, 8'hFE);
    chk(program_status_word, 8'hFF);
    for (int k = 0; k < 4; k++)
    begin
      wr(1'b0, CCSP_ADDR_STATUS, 3'h0, 8'(k << 3));
      chk(bank_base_addr, 16'(k * 8));
    end
    wr(1'b0, CCSP_ADDR_STATUS, 3'h0, 8'h00);
    wr(1'b1, CCSP_ADDR_STATUS, 3'h5, 8'h01);
    wr(1'b1, CCSP_ADDR_STATUS, 3'h1, 8'h01);
    chk(program_status_word, 8'h23);
    chk(push_addr, 8'h08);
    ex('{op: CCSP_OP_NONE, push: 1'b1, default: '0});
    chk(stack_top_ptr, 8'h08);
    wr(1'b0, CCSP_ADDR_OPERAND, 3'h0, 8'h7F);
    ar(CCSP_OP_ADD, 8'h01, 8'h00, 8'h80, 8'h67);
    ar(CCSP_OP_ADD, 8'h80, 8'h00, 8'h00, 8'hA6);
    ar(CCSP_OP_ADDC, 8'h01, 8'h00, 8'h02, 8'h23);
    ar(CCSP_OP_SUBB, 8'h03, 8'h00, 8'hFF, 8'hE2);
    wr(1'b0, CCSP_ADDR_OPERAND, 3'h0, 8'h10);
    ar(CCSP_OP_MUL, 8'h00, 8'h10, 8'h00, 8'h26);
    wr(1'b0, CCSP_ADDR_OPERAND, 3'h0, 8'h02);
    ar(CCSP_OP_MUL, 8'h00, 8'h03, 8'h06, 8'h22);
    ar(CCSP_OP_DIV, 8'h00, 8'h00, 8'h06, 8'h26);
    ar(CCSP_OP_DIV, 8'h00, 8'h03, 8'h02, 8'h23);
    rd(1'b1, CCSP_ADDR_OPERAND, 3'h1, 8'h01, 1'b1);
    ex('{op: CCSP_OP_NONE, acc_load: 1'b1, acc_value: 8'h5A, default: '0});
    chk(primary_operand_reg, 8'h5A);
    ex('{op: CCSP_OP_NONE, pop: 1'b1, default: '0});
    chk(stack_top_ptr, 8'h07);
    ex('{op: CCSP_OP_NONE, fptr_inc: 1'b1, default: '0});
    chk(flash_pointer_word, 16'h1235);
    wrap_up();
  end
endmodule : testbench
